// ==== shared/ssl_consts.vh ====
/*
  Constants for the synthesizer serial load and lock detect block:
  latch select codes, latch field positions, reset values, timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH

// Word and latch select codes
`define SSL_WORD_W        24
`define SSL_SEL_CTRL      2'h0
`define SSL_SEL_REF       2'h1
`define SSL_SEL_FB        2'h2
`define SSL_SEL_TEST      2'h3
`define SSL_LATCH_RESET   24'h000000

// Control latch fields
`define SSL_CTRL_MON_HI   7
`define SSL_CTRL_MON_LO   5
`define SSL_CTRL_PDP      8
`define SSL_CTRL_PUMP_TS  9
`define SSL_CTRL_PD1      20
`define SSL_CTRL_PD2      21

// Reference divider latch fields
`define SSL_REF_R_HI      15
`define SSL_REF_R_LO      2
`define SSL_REF_ABP_HI    17
`define SSL_REF_ABP_LO    16
`define SSL_REF_LOCK_PREC 18

// Feedback divider latch fields
`define SSL_FB_B_HI       20
`define SSL_FB_B_LO       8

// Monitor output select codes
`define SSL_MON_OFF       3'h0
`define SSL_MON_LOCK      3'h1
`define SSL_MON_REF       3'h2
`define SSL_MON_OSC       3'h3
`define SSL_MON_HIGH      3'h4

// Counts
`define SSL_LOCK_NEED_LO  3'h3
`define SSL_LOCK_NEED_HI  3'h5
`define SSL_BAND_CYCLES   3'h5

// Timing
`define SSL_CLK_NS        50
`define SSL_LOCK_SET_NS   15
`define SSL_LOCK_CLR_NS   25
`define SSL_LOCK_SET_CYC  (((`SSL_LOCK_SET_NS / `SSL_CLK_NS) < 1) ? 1 : \
                           (`SSL_LOCK_SET_NS / `SSL_CLK_NS))
`define SSL_LOCK_CLR_CYC  ((((`SSL_LOCK_CLR_NS + `SSL_CLK_NS - 1) / `SSL_CLK_NS) < 1) ? 1 : \
                           ((`SSL_LOCK_CLR_NS + `SSL_CLK_NS - 1) / `SSL_CLK_NS))

`endif

// ==== rtl/ssl_divider.v ====
/*
  Programmable event divider: one output pulse per ratio input ticks.
  Assumes ticks are single-cycle pulses in the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module ssl_divider #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         run,
  input  wire         tick,
  input  wire [W-1:0] ratio,
  output reg          pulse
);

  reg  [W-1:0] cnt;
  wire [W:0]   cnt_inc = {1'b0, cnt} + {{W{1'b0}}, 1'b1};

  // Ratio 0 or 1 gives a pulse on every tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= {W{1'b0}};
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (!run) begin
        cnt <= {W{1'b0}};
      end else if (tick) begin
        if (cnt_inc >= {1'b0, ratio}) begin
          cnt   <= {W{1'b0}};
          pulse <= 1'b1;
        end else begin
          cnt <= cnt_inc[W-1:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ssl_top.v ====
/*
  Digital programming and control of an integer-N synthesizer: serial
  word capture, four latches, reference and feedback dividers, phase
  detector, digital lock detect, monitor select, band select, power-down.
  Assumes all pins are asynchronous to core_clk and change slowly
  compared with it (the serial clock well below 10 MHz).
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssl_consts.vh"

module ssl_top (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       serial_clk,
  input  wire       serial_data,
  input  wire       load_strobe,
  input  wire       chip_enable,
  input  wire       reference_input,
  input  wire       osc_feedback,
  output reg        monitor_output,
  output reg        pump_up,
  output reg        pump_down,
  output reg        pump_oe,
  output reg  [1:0] antibacklash_width,
  output reg        lock_detect,
  output reg        power_down,
  output reg        ref_isolate_switch,
  output reg        ref_series_switch,
  output reg        band_select_active,
  output reg        tune_hold_ref
);

  localparam NPIN = 6;
  localparam P_SCLK = 0;
  localparam P_SDAT = 1;
  localparam P_LOAD = 2;
  localparam P_CE   = 3;
  localparam P_REF  = 4;
  localparam P_FB   = 5;

  // Band select states, one-hot
  localparam BS_IDLE = 2'b01;
  localparam BS_RUN  = 2'b10;

  wire [NPIN-1:0] pins = {osc_feedback, reference_input, chip_enable,
                          load_strobe, serial_data, serial_clk};
  reg  [NPIN-1:0] sync1;
  reg  [NPIN-1:0] sync2;
  reg  [NPIN-1:0] sync3;
  wire [NPIN-1:0] rise;

  reg  [`SSL_WORD_W-1:0] shift_reg;
  reg  [`SSL_WORD_W-1:0] ctrl_latch;
  reg  [`SSL_WORD_W-1:0] ref_latch;
  reg  [`SSL_WORD_W-1:0] fb_latch;
  reg  [`SSL_WORD_W-1:0] test_latch;
  reg                    fb_loaded;

  wire       pd_now;
  wire       ref_pulse;
  wire       fb_pulse;
  reg  [7:0] err_cnt;
  reg  [2:0] good_cnt;
  wire [2:0] lock_need;
  wire       cmp_done;
  wire       err_small;
  wire       err_large;
  reg  [1:0] bs_state;
  reg  [2:0] bs_cnt;
  reg        next_monitor;

  // Two flops per pin; third stage only feeds edge detection
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] & ~sync3[gi];
    end
  endgenerate

  // Chip enable low or either software power-down bit forces power-down
  assign pd_now = ~sync2[P_CE] | ctrl_latch[`SSL_CTRL_PD1]
                | ctrl_latch[`SSL_CTRL_PD2];

  // Serial shift, MSB first so select bits end up at the bottom
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= `SSL_LATCH_RESET;
    end else if (rise[P_SCLK]) begin
      shift_reg <= {shift_reg[`SSL_WORD_W-2:0], sync2[P_SDAT]};
    end
  end

  // Latch transfer; only a strobe edge touches a latch
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_latch <= `SSL_LATCH_RESET;
      ref_latch  <= `SSL_LATCH_RESET;
      fb_latch   <= `SSL_LATCH_RESET;
      test_latch <= `SSL_LATCH_RESET;
      fb_loaded  <= 1'b0;
    end else begin
      fb_loaded <= 1'b0;
      if (rise[P_LOAD]) begin
        case (shift_reg[1:0])
          `SSL_SEL_CTRL: ctrl_latch <= shift_reg;
          `SSL_SEL_REF:  ref_latch  <= shift_reg;
          `SSL_SEL_FB: begin
            fb_latch  <= shift_reg;
            fb_loaded <= 1'b1;
          end
          // Held but unused: factory use only
          default:       test_latch <= shift_reg;
        endcase
      end
    end
  end

  // Reference divider, counting reference input edges
  ssl_divider #(.W(14)) u_ref_div (
    .clk   (core_clk),
    .rst   (rst),
    .run   (~pd_now),
    .tick  (rise[P_REF]),
    .ratio (ref_latch[`SSL_REF_R_HI:`SSL_REF_R_LO]),
    .pulse (ref_pulse)
  );

  // Feedback divider, counting oscillator feedback edges
  ssl_divider #(.W(13)) u_fb_div (
    .clk   (core_clk),
    .rst   (rst),
    .run   (~pd_now),
    .tick  (rise[P_FB]),
    .ratio (fb_latch[`SSL_FB_B_HI:`SSL_FB_B_LO]),
    .pulse (fb_pulse)
  );

  // Phase error is measured once both pump flags are up
  assign cmp_done  = pump_up & pump_down;
  // Widened to the 32-bit threshold so the compare has matching operands
  assign err_small = {24'h000000, err_cnt} < `SSL_LOCK_SET_CYC;
  assign err_large = {24'h000000, err_cnt} >= `SSL_LOCK_CLR_CYC;
  assign lock_need = ref_latch[`SSL_REF_LOCK_PREC] ? `SSL_LOCK_NEED_HI
                                             : `SSL_LOCK_NEED_LO;

  // Phase/frequency detector flags; simultaneous arrival gives zero error
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
      err_cnt   <= 8'h00;
    end else if (pd_now || cmp_done) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
      err_cnt   <= 8'h00;
    end else begin
      if (ref_pulse)
        pump_up <= 1'b1;
      if (fb_pulse)
        pump_down <= 1'b1;
      // Saturating so a lost edge cannot wrap into a small error
      if ((pump_up | pump_down) && err_cnt != 8'hff)
        err_cnt <= err_cnt + 8'h01;
    end
  end

  // Digital lock detect; set and clear thresholds both one cycle, set needs lock_need good compares in a row
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      good_cnt    <= 3'h0;
      lock_detect <= 1'b0;
    end else if (pd_now) begin
      good_cnt    <= 3'h0;
      lock_detect <= 1'b0;
    end else if (cmp_done) begin
      if (lock_detect) begin
        if (err_large) begin
          lock_detect <= 1'b0;
          good_cnt    <= 3'h0;
        end
      end else if (err_small) begin
        if (good_cnt + 3'h1 >= lock_need)
          lock_detect <= 1'b1;
        good_cnt <= good_cnt + 3'h1;
      end else begin
        good_cnt <= 3'h0;
      end
    end
  end

  // Band select: five reference cycles after each feedback latch write
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bs_state           <= BS_IDLE;
      bs_cnt             <= 3'h0;
      band_select_active <= 1'b0;
      tune_hold_ref      <= 1'b0;
    end else begin
      case (bs_state)
        BS_IDLE: begin
          if (fb_loaded) begin
            bs_state           <= BS_RUN;
            bs_cnt             <= 3'h0;
            band_select_active <= 1'b1;
            tune_hold_ref      <= 1'b1;
          end
        end
        BS_RUN: begin
          // A fresh write restarts the count
          if (fb_loaded) begin
            bs_cnt <= 3'h0;
          end else if (ref_pulse) begin
            if (bs_cnt + 3'h1 >= `SSL_BAND_CYCLES) begin
              bs_state           <= BS_IDLE;
              band_select_active <= 1'b0;
              tune_hold_ref      <= 1'b0;
            end
            bs_cnt <= bs_cnt + 3'h1;
          end
        end
        default: begin
          bs_state           <= BS_IDLE;
          band_select_active <= 1'b0;
          tune_hold_ref      <= 1'b0;
        end
      endcase
    end
  end

  // Monitor source select
  always @* begin
    case (ctrl_latch[`SSL_CTRL_MON_HI:`SSL_CTRL_MON_LO])
      `SSL_MON_LOCK: next_monitor = lock_detect;
      `SSL_MON_REF:  next_monitor = ref_pulse;
      `SSL_MON_OSC:  next_monitor = fb_pulse;
      `SSL_MON_HIGH: next_monitor = 1'b1;
      default:       next_monitor = 1'b0;
    endcase
  end

  // Registered outputs for power state, pump enable and monitor
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      monitor_output     <= 1'b0;
      pump_oe            <= 1'b0;
      power_down         <= 1'b1;
      ref_isolate_switch <= 1'b1;
      ref_series_switch  <= 1'b0;
      antibacklash_width <= 2'h0;
    end else begin
      monitor_output     <= next_monitor;
      pump_oe            <= ~pd_now & ~ctrl_latch[`SSL_CTRL_PUMP_TS];
      power_down         <= pd_now;
      ref_isolate_switch <= pd_now;
      ref_series_switch  <= ~pd_now;
      antibacklash_width <= ref_latch[`SSL_REF_ABP_HI:`SSL_REF_ABP_LO];
    end
  end

endmodule

`default_nettype wire

// ==== dv/ssl_host.sv ====
/* Host controller model that drives the three-wire programming port.
   Assumes a free-running core_clk. Words are sent by calling send. */
`timescale 1ns/1ns
`default_nettype none
module ssl_host (
  input  wire logic core_clk,
  output var  logic serial_clk,
  output var  logic serial_data,
  output var  logic load_strobe
);
  // Idle pins; the serial clock only runs inside words
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Three cycles a phase keeps each pulse above the two-cycle minimum
  task automatic send(input logic [23:0] w, input logic ld);
    for (int i = 23; i >= 0; i--) begin
      serial_data <= w[i];
      wt(3);
      serial_clk <= 1'b1;
      wt(3);
      serial_clk <= 1'b0;
      serial_data <= ~w[i]; // No stale bit left on the line
      wt(3);
    end
    if (ld) begin
      load_strobe <= 1'b1;
      wt(3);
      load_strobe <= 1'b0;
    end
    wt(3);
  endtask
endmodule
`default_nettype wire

// ==== dv/ssl_top_props.sv ====
/* Port checker for ssl_top.
   Assumes binding into ssl_top, one core_clk domain. */
`timescale 1ns/1ns
`default_nettype none
module ssl_top_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       serial_clk,
  input wire logic       serial_data,
  input wire logic       load_strobe,
  input wire logic       chip_enable,
  input wire logic       reference_input,
  input wire logic       osc_feedback,
  input wire logic       monitor_output,
  input wire logic       pump_up,
  input wire logic       pump_down,
  input wire logic       pump_oe,
  input wire logic [1:0] antibacklash_width,
  input wire logic       lock_detect,
  input wire logic       power_down,
  input wire logic       ref_isolate_switch,
  input wire logic       ref_series_switch,
  input wire logic       band_select_active,
  input wire logic       tune_hold_ref
);
  // Matched and lone pump flags, for the lock relations
  wire both = pump_up & pump_down;
  wire lone = pump_up ^ pump_down;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Power state; transitions skipped since outputs may settle a cycle apart
  pd_follow_a: assert property ($fell(chip_enable) |-> ##[1:6] power_down)
    else $error("power down late");
  pump_float_a: assert property (power_down && $past(power_down) |-> !pump_oe)
    else $error("pump driven in power down");
  ref_switch_a: assert property ($stable(power_down) |->
    ref_isolate_switch == power_down && ref_series_switch != power_down)
    else $error("reference switches wrong");
  tune_hold_a: assert property (tune_hold_ref == band_select_active)
    else $error("tune hold differs from band select");
  // Band select only starts behind a load strobe
  band_start_a: assert property ($rose(band_select_active) |->
    $past(load_strobe, 3) || $past(load_strobe, 4))
    else $error("band select without load");
  // Latch fields move only after a load strobe
  abw_hold_a: assert property ($changed(antibacklash_width) |->
    $past(load_strobe, 3) || $past(load_strobe, 4))
    else $error("width changed without load");
  pump_pair_a: assert property (both |=> !pump_up && !pump_down)
    else $error("pump flags not cleared");
  lock_rise_a: assert property ($rose(lock_detect) |->
    $past(both, 1) || $past(both, 2) || $past(both, 3))
    else $error("lock without matched edges");
  lock_fall_a: assert property ($fell(lock_detect) |-> power_down ||
    !$past(chip_enable, 2) || !$past(chip_enable, 3) ||
    $past(lone, 2) || $past(lone, 3) || $past(lone, 4))
    else $error("lock dropped without wide error");
endmodule
bind ssl_top ssl_top_props u_props (
  .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .serial_data(serial_data),
  .load_strobe(load_strobe), .chip_enable(chip_enable), .reference_input(reference_input),
  .osc_feedback(osc_feedback), .monitor_output(monitor_output), .pump_up(pump_up),
  .pump_down(pump_down), .pump_oe(pump_oe), .antibacklash_width(antibacklash_width),
  .lock_detect(lock_detect), .power_down(power_down),
  .ref_isolate_switch(ref_isolate_switch), .ref_series_switch(ref_series_switch),
  .band_select_active(band_select_active), .tune_hold_ref(tune_hold_ref)
);
`default_nettype wire

// ==== dv/testbench.sv ====
/* Self-checking bench for ssl_top with a host model on the serial port.
   Assumes the design's reset and latency choices; pins driven here. */
`timescale 1ns/1ns
`default_nettype none
`include "ssl_consts.vh"
module testbench;
  logic       core_clk, rst, chip_enable, reference_input, osc_feedback;
  wire        serial_clk, serial_data, load_strobe, monitor_output, pump_up, pump_down;
  wire        pump_oe, lock_detect, power_down, ref_isolate_switch, ref_series_switch;
  wire        band_select_active, tune_hold_ref;
  wire  [1:0] antibacklash_width;
  int         mismatches, n_checks;
  logic [2:0] mons [2] = '{`SSL_MON_HIGH, `SSL_MON_OFF};
  ssl_top DUT (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .chip_enable(chip_enable), .reference_input(reference_input),
    .osc_feedback(osc_feedback), .monitor_output(monitor_output), .pump_up(pump_up),
    .pump_down(pump_down), .pump_oe(pump_oe), .antibacklash_width(antibacklash_width),
    .lock_detect(lock_detect), .power_down(power_down),
    .ref_isolate_switch(ref_isolate_switch), .ref_series_switch(ref_series_switch),
    .band_select_active(band_select_active), .tune_hold_ref(tune_hold_ref)
  );
  ssl_host u_host (
    .core_clk(core_clk), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Sampled at the edge, before it updates anything: all outputs are flops
  task automatic chk(input string nm, input logic [1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Both pins tick; the oscillator side lags by skew cycles
  task automatic ticks(input int n, input int skew);
    repeat (n) begin
      reference_input <= 1'b1;
      wt(skew);
      osc_feedback <= 1'b1;
      wt(3);
      reference_input <= 1'b0;
      osc_feedback <= 1'b0;
      wt(5);
    end
  endtask
  // Word builders, reference divider at ratio 3; none addresses the test latch
  function automatic logic [23:0] refw(input logic lock_precision_sel, input logic [1:0] abp);
    return {5'h00, lock_precision_sel, abp, 14'h0003, `SSL_SEL_REF};
  endfunction
  function automatic logic [23:0] ctlw(input logic [2:0] mon, input logic pd);
    return {3'h0, pd, 10'h000, 2'h0, mon, 3'h0, `SSL_SEL_CTRL};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 30000);
    mismatches++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    chip_enable = 1'b1;
    reference_input = 1'b0;
    osc_feedback = 1'b0;
    wt(10);
    chk("power_down", power_down, 1'b1);
    chk("ref_isolate_switch", ref_isolate_switch, 1'b1);
    rst <= 1'b0;
    wt(8);
    chk("power_down", power_down, 1'b0);
    chk("ref_series_switch", ref_series_switch, 1'b1);
    chk("pump_oe", pump_oe, 1'b1);
    $display("test power_up done");
    // Reference latch first, control next, feedback last
    u_host.send(refw(1'b0, 2'h2), 1'b1);
    chk("antibacklash_width", antibacklash_width, 2'h2);
    u_host.send(refw(1'b0, 2'h1), 1'b0);
    chk("antibacklash_width", antibacklash_width, 2'h2);
    foreach (mons[i]) begin
      u_host.send(ctlw(mons[i], 1'b0), 1'b1);
      chk("monitor_output", monitor_output, mons[i] == `SSL_MON_HIGH);
    end
    u_host.send(ctlw(`SSL_MON_OFF, 1'b1), 1'b1);
    chk("power_down", power_down, 1'b1);
    chk("ref_isolate_switch", ref_isolate_switch, 1'b1);
    chk("pump_oe", pump_oe, 1'b0);
    // Second software power-down bit, then pump three-state alone
    u_host.send(ctlw(`SSL_MON_OFF, 1'b0) | (24'h000001 << `SSL_CTRL_PD2), 1'b1);
    chk("power_down", power_down, 1'b1);
    u_host.send(ctlw(`SSL_MON_OFF, 1'b0) | (24'h000001 << `SSL_CTRL_PUMP_TS), 1'b1);
    chk("power_down", power_down, 1'b0);
    chk("pump_oe", pump_oe, 1'b0);
    u_host.send(ctlw(`SSL_MON_LOCK, 1'b0), 1'b1);
    chk("antibacklash_width", antibacklash_width, 2'h2);
    $display("test program done");
    u_host.send({3'h0, 13'h0003, 6'h00, `SSL_SEL_FB}, 1'b1);
    chk("band_select_active", band_select_active, 1'b1);
    chk("tune_hold_ref", tune_hold_ref, 1'b1);
    ticks(12, 0);
    chk("band_select_active", band_select_active, 1'b1);
    ticks(3, 0);
    chk("band_select_active", band_select_active, 1'b0);
    chk("tune_hold_ref", tune_hold_ref, 1'b0);
    $display("test band_select done");
    ticks(3, 2);
    chk("lock_detect", lock_detect, 1'b0);
    ticks(6, 0);
    chk("lock_detect", lock_detect, 1'b0);
    ticks(3, 0);
    chk("lock_detect", lock_detect, 1'b1);
    chk("monitor_output", monitor_output, 1'b1);
    ticks(3, 2);
    chk("lock_detect", lock_detect, 1'b0);
    $display("test lock_normal done");
    // Power cycle realigns both dividers after the rewrite
    u_host.send(refw(1'b1, 2'h2), 1'b1);
    chip_enable <= 1'b0;
    wt(8);
    chk("power_down", power_down, 1'b1);
    chk("pump_oe", pump_oe, 1'b0);
    chip_enable <= 1'b1;
    wt(8);
    ticks(12, 0);
    chk("lock_detect", lock_detect, 1'b0);
    ticks(3, 0);
    chk("lock_detect", lock_detect, 1'b1);
    $display("test lock_precise done");
    test_done();
  end
endmodule
`default_nettype wire
